// ===== verilog/gmcs_pkg.sv
`default_nettype none
package gmcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SRST   = 8'h08;
  localparam logic [7:0] OFS_MAXLEN = 8'h0C;
  localparam logic [7:0] OFS_BOFF   = 8'h10;
  localparam logic [7:0] OFS_EMU    = 8'h14;
  localparam logic [7:0] OFS_PRIMAP = 8'h18;
  localparam logic [7:0] OFS_IDVER  = 8'h1C;
  localparam logic [7:0] OFS_PAUSE  = 8'h20;
  // Control field positions
  localparam int C_DUPLEX = 0;
  localparam int C_LOOP   = 1;
  localparam int C_MANUFACTURING_TEST  = 2;
  localparam int C_RXFLOW = 3;
  localparam int C_TXFLOW = 4;
  localparam int C_GMIIEN = 5;
  localparam int C_PACE   = 6;
  localparam int C_GIG    = 7;
  localparam int C_IDLE   = 11;
  localparam int C_GIGF   = 17;
  localparam int C_INSEL  = 18;
  // Writable control bits, all others reserved
  localparam logic [31:0] CTRL_WMASK = 32'h01C78CFF;
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  // Status field positions
  localparam int S_IDLE  = 31;
  localparam int S_EGIG  = 4;
  localparam int S_EDUP  = 3;
  localparam int S_RXACT = 1;
  localparam int S_PAUSE = 0;
  // Backoff test field layout
  localparam int B_PACE_LO = 26;
  localparam int B_RND_LO  = 16;
  localparam int B_COLL_LO = 12;
  localparam int B_BOFF_LO = 0;
  // Reset values and the emulation write mask
  localparam logic [10:0] MAXLEN_RST = 11'h5EE;
  localparam logic [31:0] PRIMAP_RST = 32'h76543210;
  localparam logic [1:0]  EMU_WMASK  = 2'h3;
  localparam logic [15:0] PAUSE_RST  = 16'h0000;
  // Identification word, value arbitrary
  localparam logic [31:0] IDVER_VAL  = 32'h0A5A0100;
  // Pacing and backoff constants
  localparam logic [4:0] PACE_LOAD  = 5'h1F;
  localparam logic [3:0] BOFF_LIMIT = 4'hA;
  localparam int PACE_IPGS = 4;
  localparam int IPG_NS    = 96;
  localparam int CLK_MHZ   = 100;
  localparam int IPG_CYC   = (IPG_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] GAP_CYC = 8'(PACE_IPGS * IPG_CYC);
  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_GAP  = 2'b10
  } gmcs_tx_t;
endpackage
`default_nettype wire

// ===== verilog/gmcs_top.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`default_nettype none
module gmcs_top
  import gmcs_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // External mode pins
  input  wire logic        external_speed_input,
  input  wire logic        external_duplex_input,
  // PHY interface resets and duplex
  output logic             gmiiRxRst,
  output logic             gmiiTxRst,
  output logic             duplexOut,
  output logic             fullDuplexMode,
  output logic             gigMode,
  // Flow control
  input  wire logic        rxFlowTrigger,
  input  wire logic        pauseRxValid,
  input  wire logic [15:0] pauseRxQuanta,
  output logic             forceCollision,
  output logic             pauseSendReq,
  // Transmit events
  input  wire logic        txReq,
  input  wire logic        txReqIsPause,
  input  wire logic        txDone,
  input  wire logic        txCollision,
  input  wire logic        txDeferral,
  input  wire logic        slotTick,
  output logic             txGo,
  // Receive classification
  input  wire logic        rxFrameEnd,
  input  wire logic [15:0] rxByteCount,
  input  wire logic        rxFrameErr,
  input  wire logic [2:0]  rxPriIn,
  output logic             rxLongFrame,
  output logic             rxOversize,
  output logic             rxJabber,
  output logic      [2:0]  rxPriOut
);

  // Register storage
  logic [31:0] ctrl_r;     // Control word
  logic [10:0] maxLen_r;   // Receive length limit
  logic [1:0]  emu_r;      // Emulation bits
  logic [31:0] priMap_r;   // Priority map
  logic [15:0] pauseTmr_r; // Pause period remaining
  logic        srstPend_r; // Soft reset pending
  logic        macRst;     // Internal MAC logic reset
  // Transmit state
  gmcs_tx_t    txSt_r;
  gmcs_tx_t    txSt_nxt;
  logic [4:0]  paceVal_r;  // Pacing counter
  logic [7:0]  gapCnt_r;   // Pacing gap countdown
  logic [9:0]  rnd_r;      // Backoff random value
  logic [3:0]  collTally_r;
  logic        deferSeen_r; // Deferral seen by the frame in flight
  logic [9:0]  boff_r;     // Backoff counter
  logic        idle_r;
  // Pin synchronisers
  logic [1:0]  egigSync_r;
  logic [1:0]  edupSync_r;
  logic        extGig;
  logic        extDup;
  // Decoded controls
  logic        dupSel;
  logic        gigSel;
  logic        pauseActive;
  logic        rxThrottle;
  logic        ctrlWr;
  logic        testWr;

  assign ctrlWr = regWr && (regAddr == OFS_CTRL);
  assign testWr = regWr && ctrl_r[C_MANUFACTURING_TEST];

  // Two flops before the pins are used
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      egigSync_r <= 2'h0;
      edupSync_r <= 2'h0;
    end
    else
    begin
      egigSync_r <= {egigSync_r[0], external_speed_input};
      edupSync_r <= {edupSync_r[0], external_duplex_input};
    end
  end
  assign extGig = egigSync_r[1];
  assign extDup = edupSync_r[1];

  // Control word, reserved bits masked off
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_r <= CTRL_RST;
    else if (ctrlWr)
      ctrl_r <= regWdata & CTRL_WMASK;
  end

  // Plain configuration registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      maxLen_r <= MAXLEN_RST;
      emu_r    <= 2'h0;
      priMap_r <= PRIMAP_RST;
    end
    else if (regWr)
    begin
      if (regAddr == OFS_MAXLEN)
        maxLen_r <= regWdata[10:0];
      if (regAddr == OFS_EMU)
        emu_r <= regWdata[1:0] & EMU_WMASK;
      if (regAddr == OFS_PRIMAP)
        priMap_r <= regWdata & 32'h77777777;
    end
  end

  // Soft reset: one cycle of internal reset, then bit clears
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      srstPend_r <= 1'b0;
    else if (regWr && regAddr == OFS_SRST && regWdata[0])
      srstPend_r <= 1'b1;
    else
      srstPend_r <= 1'b0;
  end
  assign macRst = srstPend_r;

  // Mode resolution; external pins win in input mode
  assign dupSel = ctrl_r[C_INSEL] ? extDup : ctrl_r[C_DUPLEX];
  assign gigSel = ctrl_r[C_INSEL] ? extGig
                : (ctrl_r[C_GIG] | ctrl_r[C_GIGF]);
  assign gigMode = gigSel;
  // Loopback or gigabit override a half duplex selection
  assign fullDuplexMode = dupSel | gigSel | ctrl_r[C_LOOP];
  assign duplexOut = ctrl_r[C_DUPLEX];

  // PHY sides held in reset while disabled or soft reset
  assign gmiiRxRst = !ctrl_r[C_GMIIEN] || macRst;
  assign gmiiTxRst = !ctrl_r[C_GMIIEN] || macRst;

  // Receive flow control outputs
  assign rxThrottle = ctrl_r[C_RXFLOW] && rxFlowTrigger;
  assign forceCollision = rxThrottle && !fullDuplexMode;
  assign pauseSendReq   = rxThrottle && fullDuplexMode;

  // Pause timer: honored only in full duplex with enable
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pauseTmr_r <= PAUSE_RST;
    else if (macRst)
      pauseTmr_r <= PAUSE_RST;
    else if (pauseRxValid && fullDuplexMode && ctrl_r[C_TXFLOW])
      pauseTmr_r <= pauseRxQuanta;
    else if (testWr && regAddr == OFS_PAUSE)
      pauseTmr_r <= regWdata[15:0];
    else if (slotTick && pauseTmr_r != 16'h0000)
      pauseTmr_r <= pauseTmr_r - 16'h0001;
  end
  assign pauseActive = (pauseTmr_r != 16'h0000);

  // Only pause frames may start while paused; sends finish
  assign txGo = (txSt_r == TX_IDLE) && txReq && !gmiiTxRst
             && (!pauseActive || txReqIsPause);

  // Transmit sequencer next state
  always_comb
  begin
    txSt_nxt = txSt_r;
    case (txSt_r)
      TX_IDLE:
        if (txGo)
          txSt_nxt = TX_SEND;
      TX_SEND:
        // Clean frame with pacing active enters the long gap
        if (txDone)
          txSt_nxt = (ctrl_r[C_PACE] && paceVal_r != 5'h00
                      && collTally_r == 4'h0 && !deferSeen_r)
                     ? TX_GAP : TX_IDLE;
      TX_GAP:
        if (gapCnt_r == 8'h01)
          txSt_nxt = TX_IDLE;
      default:
        txSt_nxt = TX_IDLE;
    endcase
  end

  // Transmit sequencer state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      txSt_r <= TX_IDLE;
    else if (macRst)
      txSt_r <= TX_IDLE;
    else
      txSt_r <= txSt_nxt;
  end

  // Gap countdown of four inter-packet gaps
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gapCnt_r <= 8'h00;
    else if (txSt_r == TX_SEND && txSt_nxt == TX_GAP)
      gapCnt_r <= GAP_CYC;
    else if (gapCnt_r != 8'h00)
      gapCnt_r <= gapCnt_r - 8'h01;
  end

  // Pacing counter; collision or deferral wins over decrement
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      paceVal_r <= 5'h00;
    else if (macRst)
      paceVal_r <= 5'h00;
    else if (txCollision || txDeferral)
      paceVal_r <= PACE_LOAD;
    else if (testWr && regAddr == OFS_BOFF)
      paceVal_r <= regWdata[B_PACE_LO +: 5];
    else if (txDone && collTally_r == 4'h0 && !deferSeen_r
             && paceVal_r != 5'h00)
      paceVal_r <= paceVal_r - 5'h01;
  end

  // Free-running random source, writable in test mode
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rnd_r <= 10'h000;
    else if (testWr && regAddr == OFS_BOFF)
      rnd_r <= regWdata[B_RND_LO +: 10];
    else
      rnd_r <= rnd_r + 10'h001;
  end

  // Collisions of the frame in flight; a new frame restarts it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      collTally_r <= 4'h0;
    else if (macRst || txGo)
      collTally_r <= 4'h0;
    else if (txCollision && collTally_r != 4'hF)
      collTally_r <= collTally_r + 4'h1;
  end

  // Deferral of the frame in flight; such a frame is not clean
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      deferSeen_r <= 1'b0;
    else if (macRst)
      deferSeen_r <= 1'b0;
    else if (txDeferral)
      deferSeen_r <= 1'b1;
    else if (txGo)
      deferSeen_r <= 1'b0; // New frame starts clean
  end

  // Truncated binary backoff window, capped at ten bits
  logic [3:0] boffExp;
  logic [9:0] boffMask;
  always_comb
  begin
    boffExp  = (collTally_r >= BOFF_LIMIT - 4'h1) ? BOFF_LIMIT
             : collTally_r + 4'h1;
    boffMask = 10'((11'h001 << boffExp) - 11'h001);
  end

  // Backoff counter, one step per slot time
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      boff_r <= 10'h000;
    else if (macRst)
      boff_r <= 10'h000;
    else if (txCollision)
      boff_r <= rnd_r & boffMask;
    else if (testWr && regAddr == OFS_BOFF)
      boff_r <= regWdata[B_BOFF_LO +: 10];
    else if (slotTick && boff_r != 10'h000)
      boff_r <= boff_r - 10'h001;
  end

  // Idle reached once commanded and the transmitter is quiet
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      idle_r <= 1'b0;
    else
      idle_r <= ctrl_r[C_IDLE] && txSt_r == TX_IDLE;
  end

  // Receive length classification, one pulse per frame end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxLongFrame <= 1'b0;
      rxOversize  <= 1'b0;
      rxJabber    <= 1'b0;
    end
    else
    begin
      rxLongFrame <= rxFrameEnd
                  && rxByteCount > {5'h00, maxLen_r};
      rxOversize  <= rxFrameEnd && !rxFrameErr
                  && rxByteCount > {5'h00, maxLen_r};
      rxJabber    <= rxFrameEnd && rxFrameErr
                  && rxByteCount > {5'h00, maxLen_r};
    end
  end

  // Priority remap, registered
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rxPriOut <= 3'h0;
    else
      rxPriOut <= priMap_r[{rxPriIn, 2'b00} +: 3];
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      regRdata <= 32'h00000000;
    else if (!regRd)
      regRdata <= 32'h00000000;
    else
      case (regAddr)
        OFS_CTRL:   regRdata <= ctrl_r;
        OFS_STATUS: regRdata <= {idle_r, 26'h0, extGig, extDup, 1'b0,
                                 rxThrottle, pauseActive};
        OFS_SRST:   regRdata <= {31'h0, srstPend_r};
        OFS_MAXLEN: regRdata <= {21'h0, maxLen_r};
        OFS_BOFF:   regRdata <= {1'b0, paceVal_r, rnd_r, collTally_r,
                                 2'h0, boff_r};
        OFS_EMU:    regRdata <= {30'h0, emu_r};
        OFS_PRIMAP: regRdata <= priMap_r;
        OFS_IDVER:  regRdata <= IDVER_VAL;
        OFS_PAUSE:  regRdata <= {16'h0, pauseTmr_r};
        default:    regRdata <= 32'h00000000; // Unmapped reads zero
      endcase
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_srstWrite;
    regWr && regAddr == OFS_SRST && regWdata[0];
  endsequence
  sequence s_srstDone;
    srstPend_r ##1 !srstPend_r;
  endsequence

  a_enable_reset: assert property (
    !ctrl_r[C_GMIIEN] |-> gmiiRxRst && gmiiTxRst)
    else $error("PHY sides not held in reset");
  a_pause_honor: assert property (
    pauseRxValid && !fullDuplexMode && !macRst
    && !(testWr && regAddr == OFS_PAUSE)
    && $past(pauseTmr_r) == 16'h0 && pauseTmr_r == 16'h0
    |=> pauseTmr_r == 16'h0)
    else $error("Pause acted upon in half duplex");
  a_flow_split: assert property (
    (ctrl_r[C_RXFLOW] && rxFlowTrigger)
    ? (forceCollision == !fullDuplexMode && pauseSendReq == fullDuplexMode)
    : (!forceCollision && !pauseSendReq))
    else $error("Flow control action wrong for duplex");
  a_test_lock: assert property (
    regWr && regAddr == OFS_BOFF && !ctrl_r[C_MANUFACTURING_TEST] && !txCollision
    && !slotTick && !macRst |=> boff_r == $past(boff_r))
    else $error("Backoff written outside test mode");
  a_duplex_force: assert property (
    (ctrl_r[C_LOOP] || gigSel) |-> fullDuplexMode)
    else $error("Forced full duplex missing");
  a_duplex_out: assert property (
    $rose(ctrlWr && regWdata[C_DUPLEX]) |=> duplexOut)
    else $error("Duplex output not following bit");
  a_srst_clear: assert property (
    s_srstWrite |=> s_srstDone)
    else $error("Soft reset bit did not clear");
  a_pace_load: assert property (
    txCollision && !macRst |=> paceVal_r == PACE_LOAD)
    else $error("Pacing counter not loaded");
  a_pace_gap: assert property (
    txSt_r == TX_SEND && txSt_nxt == TX_GAP
    |=> (txSt_r == TX_GAP && !txGo) [*8])
    else $error("Pacing gap too short");
  a_pause_block: assert property (
    pauseActive && !txReqIsPause |-> !txGo)
    else $error("Transmit started during pause");
  a_jabber_class: assert property (
    rxFrameEnd && rxFrameErr && rxByteCount > {5'h00, maxLen_r}
    |=> rxJabber && !rxOversize)
    else $error("Errored long frame not jabber");
  a_pri_remap: assert property (
    ##1 rxPriOut == $past(priMap_r[{rxPriIn, 2'b00} +: 3]))
    else $error("Priority not remapped");

endmodule // gmcs_top
`default_nettype wire

// ===== testbench/gmcs_phy_model.sv
`default_nettype none
module gmcs_phy_model
  import gmcs_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Transmit handshake
  input  wire logic       txGo,
  input  wire logic [1:0] faultKind,
  output logic            txDone,
  output logic            txCollision,
  output logic            txDeferral,
  output logic            slotTick
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt_r;  // Frame cycles left
  int unsigned slot_r; // Slot divider

  // Six-cycle frames; a fault lands mid-frame only when the bench asks
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r       <= 0;
      txDone      <= 1'b0;
      txCollision <= 1'b0;
      txDeferral  <= 1'b0;
    end
    else
    begin
      txDone      <= (cnt_r == 1);
      txCollision <= (cnt_r == 4) && (faultKind == 2'h1);
      txDeferral  <= (cnt_r == 4) && (faultKind == 2'h2);
      if (txGo)
        cnt_r <= 6;
      else if (cnt_r != 0)
        cnt_r <= cnt_r - 1;
    end
  end

  // Slot time of eight cycles keeps pause waits short
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      slot_r <= 0;
    else
      slot_r <= (slot_r + 1) % 8;
  end
  assign slotTick = (slot_r == 7);
endmodule // gmcs_phy_model
`default_nettype wire

// ===== testbench/tb_gigabit_mac_control_status.sv
`default_nettype none
module tb_gigabit_mac_control_status
  import gmcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, regWr, regRd, gmiiRxRst, gmiiTxRst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, d, v, m;
  logic        external_speed_input, external_duplex_input;
  logic        duplexOut, fullDuplexMode, gigMode, rxFlowTrigger;
  logic        pauseRxValid, forceCollision, pauseSendReq, txGo;
  logic [15:0] pauseRxQuanta, rxByteCount;
  logic        txReq, txReqIsPause, txDone, txCollision, txDeferral;
  logic        slotTick, rxFrameEnd, rxFrameErr;
  logic        rxLongFrame, rxOversize, rxJabber;
  logic [2:0]  rxPriIn, rxPriOut;
  logic [1:0]  faultKind;
  int          nMismatch, samplesChecked, w, i, paceM;

  gmcs_top gmcs_top_i (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .external_speed_input, .external_duplex_input, .gmiiRxRst,
    .gmiiTxRst, .duplexOut, .fullDuplexMode, .gigMode, .rxFlowTrigger,
    .pauseRxValid, .pauseRxQuanta, .forceCollision, .pauseSendReq, .txReq,
    .txReqIsPause, .txDone, .txCollision, .txDeferral, .slotTick, .txGo,
    .rxFrameEnd, .rxByteCount, .rxFrameErr, .rxPriIn, .rxLongFrame,
    .rxOversize, .rxJabber, .rxPriOut);
  gmcs_phy_model gmcs_phy_model_i (.mclk, .rst, .txGo, .faultKind, .txDone,
    .txCollision, .txDeferral, .slotTick);

  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic summarize();
    if (nMismatch == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare one result
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    regAddr  <= a;
    regWdata <= x;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask

  // Register read, data sampled mid-cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    x = regRdata;
    @(posedge mclk);
  endtask

  // One frame: hold request until accepted, then wait for its end
  task automatic sendFrame(input logic isPause, output int n);
    int k;
    n = 0;
    txReqIsPause <= isPause;
    txReq        <= 1'b1;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (txGo !== 1'b1 && n < 300);
    @(posedge mclk);
    txReq <= 1'b0;
    for (k = 0; k < 50 && txDone !== 1'b1; k++)
      @(negedge mclk);
    if (n >= 300 || k >= 50)
    begin
      chk(32'h0, 32'h1);
      summarize();
    end
    if (faultKind != 2'h0)
      paceM = 31;
    else if (paceM > 0)
      paceM--;
    @(posedge mclk);
  endtask

  initial
  begin
    {regWr, regRd, rxFlowTrigger, pauseRxValid, txReq, txReqIsPause} = '0;
    {rxFrameEnd, rxFrameErr, external_speed_input} = '0;
    external_duplex_input = 1'b0;
    {regAddr, regWdata, pauseRxQuanta, rxByteCount} = '0;
    rxPriIn   = 3'h0;
    faultKind = 2'h0;
    paceM     = 0;
    nMismatch = 0;
    samplesChecked = 0;
    void'($urandom(32'h934370d9));
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values, unmapped and reserved places
    rd(OFS_CTRL, d); chk(d, CTRL_RST);
    rd(OFS_MAXLEN, d); chk(d, {21'h0, MAXLEN_RST});
    rd(OFS_PRIMAP, d); chk(d, PRIMAP_RST);
    rd(8'h3C, d); chk(d, 32'h0);
    wr(OFS_EMU, 32'hFFFFFFFF);
    rd(OFS_EMU, d); chk(d, {30'h0, EMU_WMASK});
    wr(OFS_IDVER, 32'h0);
    rd(OFS_IDVER, d); chk(d, IDVER_VAL);
    chk({gmiiRxRst, gmiiTxRst}, 2'h3);
    wr(OFS_CTRL, 32'hFFFFFFDF);
    rd(OFS_CTRL, d); chk(d, CTRL_WMASK & 32'hFFFFFFDF);
    wr(OFS_CTRL, 32'hFFFFFFFF);
    @(negedge mclk); chk({gmiiRxRst, gmiiTxRst}, 2'h0);
    @(posedge mclk);
    wr(OFS_CTRL, 32'hFFFFFFDF);
    wr(OFS_CTRL, 32'h0); // Loopback moved only while disabled
    // Duplex and speed selection from register bits
    for (i = 0; i < 16; i++)
    begin
      v = $urandom & 32'h00020083;
      wr(OFS_CTRL, v);
      @(negedge mclk);
      chk(duplexOut, v[0]);
      chk(fullDuplexMode, v[0] | v[1] | v[7] | v[17]);
      chk(gigMode, v[7] | v[17]);
      @(posedge mclk);
    end
    // Duplex and speed from the external pins
    for (i = 0; i < 4; i++)
    begin
      external_speed_input  <= i[1];
      external_duplex_input <= i[0];
      wr(OFS_CTRL, 32'h00040000 | 32'($urandom & 1));
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk(gigMode, i[1]);
      chk(fullDuplexMode, i[0] | i[1]);
      @(posedge mclk);
      rd(OFS_STATUS, d); chk(d[4:3], i[1:0]);
    end
    // Receive flow control in both duplex modes
    for (i = 0; i < 8; i++)
    begin
      rxFlowTrigger <= i[1];
      wr(OFS_CTRL, 32'(i[2]) | (32'(i[0]) << 3));
      @(negedge mclk);
      chk(forceCollision, i[0] & i[1] & ~i[2]);
      chk(pauseSendReq, i[0] & i[1] & i[2]);
      @(posedge mclk);
      rd(OFS_STATUS, d); chk(d[1], i[0] & i[1]);
    end
    rxFlowTrigger <= 1'b0;
    // Test registers locked without test mode
    wr(OFS_CTRL, 32'h21);
    wr(OFS_PAUSE, 32'h100);
    wr(OFS_BOFF, 32'h14000000);
    rd(OFS_STATUS, d); chk(d[0], 1'b0);
    rd(OFS_BOFF, d); chk(d[30:26], 5'h0);
    wr(OFS_CTRL, 32'h25);
    wr(OFS_PAUSE, 32'h100);
    rd(OFS_STATUS, d); chk(d[0], 1'b1);
    wr(OFS_PAUSE, 32'h0);
    // Received pause: half, full honoured, full not honoured
    for (i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL, (i == 0) ? 32'h30 : ((i == 1) ? 32'h31 : 32'h21));
      pauseRxQuanta <= 16'h0004;
      pauseRxValid  <= 1'b1;
      @(posedge mclk);
      pauseRxValid <= 1'b0;
      @(posedge mclk);
      rd(OFS_STATUS, d); chk(d[0], i == 1);
      txReqIsPause <= 1'b0;
      txReq        <= 1'b1;
      w = 0;
      repeat (5)
      begin
        @(negedge mclk);
        w += (txGo === 1'b1);
      end
      @(posedge mclk);
      txReq <= 1'b0;
      if (i == 1)
      begin
        chk(w, 0);
        @(posedge mclk);
        sendFrame(1'b1, w); chk(w <= 3, 1'b1);
        repeat (60) @(posedge mclk);
        rd(OFS_STATUS, d); chk(d[0], 1'b0);
      end
      else
      begin
        chk(w > 0, 1'b1);
        repeat (10) @(posedge mclk);
      end
    end
    // Pacing, tally and backoff after faults
    wr(OFS_CTRL, 32'h61);
    faultKind <= 2'h1;
    sendFrame(1'b0, w);
    rd(OFS_BOFF, d);
    chk(d[30:26], paceM);
    chk(d[15:12], 4'h1);
    chk(d[9:1], 9'h0);
    faultKind <= 2'h0;
    sendFrame(1'b0, w); chk(w <= 3, 1'b1);
    sendFrame(1'b0, w); chk(w >= 38 && w <= 44, 1'b1);
    rd(OFS_BOFF, d); chk(d[30:26], paceM);
    faultKind <= 2'h2;
    sendFrame(1'b0, w);
    faultKind <= 2'h0;
    rd(OFS_BOFF, d); chk(d[30:26], paceM);
    rd(OFS_BOFF, v); chk(d[25:16] != v[25:16], 1'b1);
    wr(OFS_CTRL, 32'h21);
    sendFrame(1'b0, w);
    sendFrame(1'b0, w); chk(w <= 3, 1'b1);
    // Soft reset: a read right after the write still sees it pending
    regAddr  <= OFS_SRST;
    regWdata <= 32'h1;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(regRdata, 32'h1);
    @(posedge mclk);
    w = 0;
    do
    begin
      rd(OFS_SRST, d);
      w++;
    end
    while (d !== 32'h0 && w < 5);
    chk(d, 32'h0);
    rd(OFS_BOFF, d); chk(d[30:26], 5'h0);
    rd(OFS_CTRL, d); chk(d, 32'h21);
    // Idle status follows the idle command
    rd(OFS_STATUS, d); chk(d[31], 1'b0);
    wr(OFS_CTRL, 32'h821);
    rd(OFS_STATUS, d); chk(d[31], 1'b1);
    // Length limit and long-frame classes
    wr(OFS_MAXLEN, 32'hFFFFFFFF);
    rd(OFS_MAXLEN, d); chk(d, 32'h7FF);
    m = 32'd64 + ($urandom % 1900);
    wr(OFS_MAXLEN, m);
    for (i = 0; i < 6; i++)
    begin
      rxByteCount <= 16'(m + i / 2);
      rxFrameErr  <= i[0];
      rxFrameEnd  <= 1'b1;
      @(posedge mclk);
      rxFrameEnd <= 1'b0;
      @(negedge mclk);
      chk(rxLongFrame, i >= 2);
      chk({rxOversize, rxJabber}, {i >= 2 && !i[0], i >= 2 && i[0]});
      @(posedge mclk);
    end
    // Priority remapping through a random map
    m = $urandom & 32'h77777777;
    wr(OFS_PRIMAP, m | 32'h88888888);
    rd(OFS_PRIMAP, d); chk(d, m);
    for (i = 0; i < 8; i++)
    begin
      rxPriIn <= 3'(i);
      @(posedge mclk);
      @(negedge mclk);
      chk(rxPriOut, m[4 * i +: 3]);
      @(posedge mclk);
    end
    summarize();
  end
endmodule // tb_gigabit_mac_control_status
`default_nettype wire
